//--- core/tpm_dead_time.sv
// One phase dead-time timer: holds back each turn-on until the count expires.
// Assumes trig, tick and the turn-on requests come from logic on ref_clk.
`timescale 1ns/10ps
module tpm_dead_time
	import tpm_pkg::*;
#(
	parameter int DT_W = 8
) (
	input  wire logic            ref_clk,
	input  wire logic            sys_rst,
	input  wire logic            trig,
	input  wire logic            tick,
	input  wire logic            dtDisable,
	input  wire logic [DT_W-1:0] reload,
	input  wire logic            onHigh,
	input  wire logic            onLow,
	output logic                 actHigh,
	output logic                 actLow
);
	typedef struct packed {
		logic [DT_W-1:0] count;
		logic            actH;
		logic            actL;
	} tpm_dt_state_t;

	tpm_dt_state_t s;
	tpm_dt_state_t next_s;
	logic          expired;

	always_comb begin
		next_s = s;
		if (trig) begin
			next_s.count = reload;
		end else if (tick && s.count != '0) begin
			next_s.count = s.count - DT_W'(1);
		end
		// Turn-off passes at once; only turn-on waits
		expired = dtDisable || (s.count == '0 && !trig);
		next_s.actH = onHigh && expired;
		next_s.actL = onLow && expired;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign actHigh = s.actH;
	assign actLow  = s.actL;
endmodule : tpm_dead_time

//--- core/tpm_phase_timer.sv
// One phase one-shot timer: counts a reload value after each start trigger.
// Assumes start is a one-cycle pulse on ref_clk.
`timescale 1ns/10ps
module tpm_phase_timer
	import tpm_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             start,
	input  wire logic             altEnable,
	input  wire logic [CNT_W-1:0] reloadPri,
	input  wire logic [CNT_W-1:0] reloadSec,
	output logic                  pulse,
	output logic                  fall
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic             busy;
		logic             useSec;
		logic             fall;
	} tpm_pt_state_t;

	tpm_pt_state_t s;
	tpm_pt_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.fall = 1'b0;
		if (start) begin
			next_s.busy = 1'b1;
			next_s.count = (altEnable && s.useSec) ? reloadSec : reloadPri;
			if (next_s.count == '0) begin
				next_s.count = CNT_W'(1);
			end
		end else if (s.busy) begin
			if (s.count <= CNT_W'(1)) begin
				next_s.busy = 1'b0;
				next_s.fall = 1'b1;
				next_s.useSec = altEnable ? ~s.useSec : 1'b1;
			end else begin
				next_s.count = s.count - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.useSec <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign pulse = s.busy;
	assign fall  = s.fall;
endmodule : tpm_phase_timer

//--- core/tpm_pkg.sv
// Constants, register map and pin types of the three-phase PWM output stage.
// Assumes one 25 MHz clock and an APB master with 12-bit byte addresses.
// Operation
// - Shutdown low with cutoff enabled clears output enable
// - Forced cutoff floats all six pins
// - Select bit routes pin: 1 PWM, 0 GPIO
// - Pin select only effective while output enabled
// - Pin select writes ignored unless unlocked
// - Unlock bit holds; software relocks after writing
// - Triangular carrier spans two underflows, sawtooth one
// - Underflow or stopped carrier write starts phases
// - Interrupt every n underflows in mode 0/sawtooth
// - Mode 1 interrupt on selected timing; 11b first at n-1
// - Phase one-shot; output changes on its falling edge
// - Mode 1 alternates secondary and primary reloads
// - Three 8-bit dead timers share one reload
// - Dead time disable bit; clock select bit
// - Dead trigger: pattern rising edge or one-shot fall
// - Sawtooth transfer triggers dead timers too
// - First buffer drives first, second at next fall
// - Transfer trigger sources per modulation and software
// - Pattern 0 means on; active level selectable
// - Conduction guard clears enable, flags, floats pins
// - Pin carries PWM when function, enable, select set
// - Dead timer delays turn-on to avoid shoot-through
package tpm_pkg;

	// ***********************************************
	// Register offsets
	// ***********************************************
	localparam logic [11:0] OFS_CTRLA    = 12'h300;
	localparam logic [11:0] OFS_CTRLB    = 12'h304;
	localparam logic [11:0] OFS_CARRIER  = 12'h308;
	localparam logic [11:0] OFS_CARCTL   = 12'h30C;
	localparam logic [11:0] OFS_PINSEL   = 12'h318;
	localparam logic [11:0] OFS_PROTECT  = 12'h31C;
	localparam logic [11:0] OFS_PRI_U    = 12'h320;
	localparam logic [11:0] OFS_SEC_W    = 12'h334;
	localparam logic [11:0] OFS_DEADTIME = 12'h338;
	localparam logic [11:0] OFS_SKIP     = 12'h33C;
	localparam logic [11:0] OFS_PAT0     = 12'h340;
	localparam logic [11:0] OFS_PAT1     = 12'h344;
	localparam logic [11:0] OFS_STATUS   = 12'h348;

	// ***********************************************
	// Field positions and reset values
	// ***********************************************
	localparam int CA_MTF    = 2;
	localparam int CA_MOE    = 3;
	localparam int CA_GUARD  = 4;
	localparam int CA_DETECT = 5;
	localparam int CA_SAW    = 6;
	localparam int CA_SWTRIG = 7;
	localparam int CB_STOPWR = 0;
	localparam int CB_MODE1  = 1;
	localparam int CB_DTCLK  = 2;
	localparam int CB_ACTHI  = 4;
	localparam int CB_DTDIS  = 5;
	localparam int CB_DTTRIG = 6;
	localparam int CC_RUN    = 0;
	localparam int CC_HIZ    = 1;
	localparam logic [5:0] PINSEL_RST = 6'h3F;
	localparam logic [5:0] PAT_RST    = 6'h3F;
	localparam logic [2:0] SYNC_RST   = 3'h7;

	// Six pins: bit 2p is the high side of phase p, bit 2p+1 the low side
	typedef struct packed {
		logic [5:0] level;
		logic [5:0] oeN;
	} tpm_pins_t;

endpackage : tpm_pkg

//--- core/tpm_pwm_core.sv
// Three-phase PWM output stage with APB register access and six phase pins.
// Assumes the shutdown input is asynchronous and gpioPins come from the port logic.
`timescale 1ns/10ps
module tpm_pwm_core
	import tpm_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int DT_W  = 8
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        shutdownInputN,
	input  wire tpm_pins_t   gpioPins,
	output tpm_pins_t        phasePins,
	output logic             carrierIrq
);
	// ***********************************************
	// Parameter checks
	// ***********************************************
	generate
		if (CNT_W < 2 || CNT_W > 32 || DT_W < 1 || DT_W > 8) begin : g_bad_param
			$error("tpm_pwm_core: unsupported counter width");
		end
	endgenerate

	// ***********************************************
	// State
	// ***********************************************
	typedef struct packed {
		logic [7:0]            ctrlA;
		logic [7:0]            ctrlB;
		logic [CNT_W-1:0]      carrierReload;
		logic [CNT_W-1:0]      carrierCnt;
		logic                  carrierRun;
		logic                  carrierDir;
		logic                  hizEnable;
		logic [5:0]            pinSelect;
		logic                  unlock;
		logic [5:0][CNT_W-1:0] reloads;
		logic [DT_W-1:0]       deadTime;
		logic [7:0]            skip;
		logic [7:0]            skipCnt;
		logic [5:0]            pat0;
		logic [5:0]            pat1;
		logic                  written0;
		logic                  written1;
		logic [5:0]            shiftOut;
		logic [5:0]            second;
		logic [2:0]            sdSync;
		logic                  sdLevel;
		logic                  cutoff;
		logic                  dtDiv;
		tpm_pins_t             pins;
		logic                  irq;
		logic                  pready;
		logic                  pslverr;
		logic [31:0]           prdata;
	} tpm_core_state_t;

	tpm_core_state_t s;
	tpm_core_state_t next_s;

	logic [2:0] ptFall;
	logic [2:0] dtTrig;
	logic [2:0] actH;
	logic [2:0] actL;
	logic       startTrig;
	logic       transfer;
	logic       underflow;
	logic       stoppedWr;
	logic       wrEn;
	logic       mode1;
	logic       saw;
	logic       dtTick;

	// Reload registers: index 0..2 primary U/V/W, 3..5 secondary U/V/W
	function automatic logic reloadHit(input logic [11:0] a);
		return a >= OFS_PRI_U && a <= OFS_SEC_W && a[1:0] == 2'h0;
	endfunction : reloadHit

	function automatic logic [2:0] reloadIdx(input logic [11:0] a);
		logic [11:0] d;
		d = a - OFS_PRI_U;
		return d[4:2];
	endfunction : reloadIdx

	function automatic logic [31:0] readReg(input tpm_core_state_t r, input logic [11:0] a,
		output logic miss);
		logic [31:0] v;
		v = '0;
		miss = 1'b0;
		if (reloadHit(a)) begin
			v[CNT_W-1:0] = r.reloads[reloadIdx(a)];
		end else begin
			unique case (a)
				OFS_CTRLA:    v[7:0] = r.ctrlA;
				OFS_CTRLB:    v[7:0] = r.ctrlB;
				OFS_CARRIER:  v[CNT_W-1:0] = r.carrierCnt;
				OFS_CARCTL:   v[1:0] = {r.hizEnable, r.carrierRun};
				OFS_PINSEL:   v[5:0] = r.pinSelect;
				OFS_PROTECT:  v[0] = r.unlock;
				OFS_DEADTIME: v[DT_W-1:0] = r.deadTime;
				OFS_SKIP:     v[7:0] = r.skip;
				OFS_PAT0:     v[5:0] = r.shiftOut;
				OFS_PAT1:     v[5:0] = r.second;
				OFS_STATUS:   v[2:0] = {r.carrierDir, r.cutoff, r.sdLevel};
				default:      miss = 1'b1;
			endcase
		end
		return v;
	endfunction : readReg

	// ***********************************************
	// Phase timers and dead-time timers
	// ***********************************************
	generate
		for (genvar p = 0; p < 3; p++) begin : g_phase
			tpm_phase_timer #(
				.CNT_W     (CNT_W)
			) u_timer (
				.ref_clk   (ref_clk),
				.sys_rst   (sys_rst),
				.start     (startTrig),
				.altEnable (mode1),
				.reloadPri (s.reloads[p]),
				.reloadSec (s.reloads[p+3]),
				.pulse     (),
				.fall      (ptFall[p])
			);
			tpm_dead_time #(
				.DT_W      (DT_W)
			) u_dead (
				.ref_clk   (ref_clk),
				.sys_rst   (sys_rst),
				.trig      (dtTrig[p]),
				.tick      (dtTick),
				.dtDisable (s.ctrlB[CB_DTDIS]),
				.reload    (s.deadTime),
				.onHigh    (~s.shiftOut[2*p]),
				.onLow     (~s.shiftOut[2*p+1]),
				.actHigh   (actH[p]),
				.actLow    (actL[p])
			);
		end
	endgenerate

	// ***********************************************
	// Next-state logic
	// ***********************************************
	always_comb begin
		logic       miss;
		logic       event_;
		logic       drive;
		logic       floatAll;
		logic       lvl;
		logic [5:0] effSel;
		logic [1:0] oldPair;
		logic [1:0] newPair;
		miss = 1'b0;
		event_ = 1'b0;
		drive = 1'b0;
		floatAll = 1'b0;
		lvl = 1'b0;
		effSel = '0;
		oldPair = '0;
		newPair = '0;
		next_s = s;
		next_s.irq = 1'b0;
		mode1 = s.ctrlB[CB_MODE1] && !s.ctrlA[CA_SAW];
		saw = s.ctrlA[CA_SAW];

		// APB: one wait state; the read is sampled at the edge raising pready, the write lands at the edge after it
		wrEn = psel && penable && pwrite && s.pready;
		next_s.pready = psel && penable && !s.pready;
		next_s.pslverr = 1'b0;
		if (psel && penable && !s.pready) begin
			next_s.prdata = readReg(s, paddr, miss);
			next_s.pslverr = miss;
			if (pwrite) begin
				next_s.prdata = '0;
			end
		end

		// Shutdown input: three flops, a change counts when the last two agree
		next_s.sdSync = {s.sdSync[1:0], shutdownInputN};
		if (s.sdSync[1] == s.sdSync[2]) begin
			next_s.sdLevel = s.sdSync[2];
		end

		// Carrier timer
		underflow = s.carrierRun && s.carrierCnt == '0;
		stoppedWr = wrEn && paddr == OFS_CARRIER && !s.carrierRun;
		if (s.carrierRun) begin
			if (underflow) begin
				next_s.carrierCnt = s.carrierReload;
				next_s.carrierDir = ~s.carrierDir;
			end else begin
				next_s.carrierCnt = s.carrierCnt - CNT_W'(1);
			end
		end
		startTrig = underflow || (stoppedWr && s.ctrlB[CB_STOPWR]);
		transfer = (underflow && (saw || (s.written0 && s.written1)))
			|| (stoppedWr && s.ctrlB[CB_STOPWR])
			|| (wrEn && paddr == OFS_CTRLA && pwdata[CA_SWTRIG]);
		if (transfer) begin
			next_s.written0 = 1'b0;
			next_s.written1 = 1'b0;
		end

		// Register writes
		if (wrEn) begin
			if (reloadHit(paddr)) begin
				next_s.reloads[reloadIdx(paddr)] = pwdata[CNT_W-1:0];
			end
			unique case (paddr)
				OFS_CTRLA: begin
					next_s.ctrlA = pwdata[7:0];
					next_s.ctrlA[CA_SWTRIG] = 1'b0;
					next_s.ctrlA[CA_DETECT] = s.ctrlA[CA_DETECT] && pwdata[CA_DETECT];
				end
				OFS_CTRLB: next_s.ctrlB = pwdata[7:0];
				OFS_CARRIER: begin
					next_s.carrierReload = pwdata[CNT_W-1:0];
					if (!s.carrierRun) begin
						next_s.carrierCnt = pwdata[CNT_W-1:0];
					end
				end
				OFS_CARCTL: begin
					next_s.carrierRun = pwdata[CC_RUN];
					next_s.hizEnable = pwdata[CC_HIZ];
				end
				OFS_PINSEL: begin
					if (s.unlock) begin
						next_s.pinSelect = pwdata[5:0];
					end
				end
				OFS_PROTECT: next_s.unlock = pwdata[0];
				OFS_DEADTIME: next_s.deadTime = pwdata[DT_W-1:0];
				OFS_SKIP: begin
					next_s.skip = pwdata[7:0];
					next_s.skipCnt = (mode1 && s.ctrlA[1:0] == 2'h3) ?
						pwdata[7:0] - 8'h01 : pwdata[7:0];
				end
				OFS_PAT0: begin
					next_s.pat0 = pwdata[5:0];
					next_s.written0 = 1'b1;
				end
				OFS_PAT1: begin
					next_s.pat1 = pwdata[5:0];
					next_s.written1 = 1'b1;
				end
				default: ;
			endcase
		end

		// Carrier interrupt decimation
		if (mode1) begin
			unique case (s.ctrlA[1:0])
				2'h1:    event_ = underflow && !s.carrierDir;
				2'h2:    event_ = underflow && s.carrierDir;
				default: event_ = underflow;
			endcase
		end else begin
			event_ = underflow;
		end
		if (event_) begin
			if (s.skipCnt <= 8'h01) begin
				next_s.irq = 1'b1;
				next_s.skipCnt = s.skip;
			end else begin
				next_s.skipCnt = s.skipCnt - 8'h01;
			end
		end

		// Output shift registers and dead-time triggers
		if (transfer) begin
			next_s.shiftOut = s.pat0;
			next_s.second = s.pat1;
		end
		for (int p = 0; p < 3; p++) begin
			if (!transfer && ptFall[p]) begin
				next_s.shiftOut[2*p +: 2] = s.second[2*p +: 2];
			end
			oldPair = s.shiftOut[2*p +: 2];
			newPair = next_s.shiftOut[2*p +: 2];
			dtTrig[p] = (s.ctrlB[CB_DTTRIG] ? |(newPair & ~oldPair) : ptFall[p])
				|| (saw && transfer);
		end
		next_s.dtDiv = ~s.dtDiv;
		dtTick = !s.ctrlB[CB_DTCLK] || s.dtDiv;

		// Forced cutoff; hardware wins over a same-cycle software write
		if (!s.hizEnable) begin
			next_s.cutoff = 1'b0;
		end
		if (!s.sdLevel && s.hizEnable) begin
			next_s.cutoff = 1'b1;
			next_s.ctrlA[CA_MOE] = 1'b0;
		end

		// Simultaneous conduction guard
		if (s.ctrlA[CA_GUARD] && |(actH & actL)) begin
			next_s.ctrlA[CA_MOE] = 1'b0;
			next_s.ctrlA[CA_DETECT] = 1'b1;
		end

		// Pin multiplexing
		effSel = s.ctrlA[CA_MOE] ? s.pinSelect : 6'h00;
		floatAll = s.cutoff || (s.ctrlA[CA_GUARD] && s.ctrlA[CA_DETECT]);
		for (int i = 0; i < 6; i++) begin
			drive = s.ctrlA[CA_MTF] && s.ctrlA[CA_MOE] && effSel[i];
			lvl = (i % 2 == 0) ? actH[i/2] : actL[i/2];
			lvl = lvl ? s.ctrlB[CB_ACTHI] : ~s.ctrlB[CB_ACTHI];
			next_s.pins.level[i] = drive ? lvl : gpioPins.level[i];
			next_s.pins.oeN[i] = floatAll ? 1'b1 : (drive ? 1'b0 : gpioPins.oeN[i]);
		end
	end

	// ***********************************************
	// Registers
	// ***********************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.pinSelect <= PINSEL_RST;
			s.pat0 <= PAT_RST;
			s.pat1 <= PAT_RST;
			s.shiftOut <= PAT_RST;
			s.second <= PAT_RST;
			s.sdSync <= SYNC_RST;
			s.sdLevel <= 1'b1;
			s.pins.oeN <= 6'h3F;
		end else begin
			s <= next_s;
		end
	end

	assign prdata     = s.prdata;
	assign pready     = s.pready;
	assign pslverr    = s.pslverr;
	assign phasePins  = s.pins;
	assign carrierIrq = s.irq;
endmodule : tpm_pwm_core

//--- verif/test_tpm_pwm_core.sv
// Self-checking bench for the PWM output stage driven over APB.
// Assumes the checker binds itself and the gate model watches the pins.
`timescale 1ns/10ps
module test_tpm_pwm_core
	import tpm_pkg::*;
();
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic        e;
	} tpm_note_t;
	logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, sdN, carrierIrq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, lfsr;
	logic [5:0]  gateSeen, sel, p0;
	tpm_pins_t   gpioPins, phasePins;
	tpm_note_t   noteQ[$];
	int          numErrors, checks, gap;
	int          gaps[6] = '{30, 30, 30, 60, 60, 30};
	tpm_pwm_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shutdownInputN(sdN), .gpioPins(gpioPins), .phasePins(phasePins),
		.carrierIrq(carrierIrq));
	tpm_gate_model gate_u (.phasePins(phasePins), .gateSeen(gateSeen));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// ****
	// Tasks
	// ****
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic fail(input string msg);
		numErrors++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask : fail
	task automatic final_report();
		$display("errors %0d checks %0d", numErrors, checks);
		if (numErrors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic cmp_bus(input tpm_note_t n);
		checks++;
		if (((prdata & n.m) !== (n.d & n.m)) || (pslverr !== n.e)) fail("bus answer");
	endtask : cmp_bus
	task automatic cmp_pins(input logic [5:0] lvl, input logic [5:0] oe);
		checks++;
		if (phasePins.oeN !== oe || (phasePins.level & ~oe) !== (lvl & ~oe)) fail("pin state");
		if (gateSeen !== (lvl & ~oe)) fail("gate input");
	endtask : cmp_pins
	task automatic cmp_gap(input int got, input int exp);
		checks++;
		if (got != exp) fail("interrupt spacing");
	endtask : cmp_gap
	// Callers enter right after a rising edge and leave right after one
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic e);
		int k;
		noteQ.push_back('{d, m, e});
		{psel, penable, pwrite} <= {1'b1, 1'b0, w};
		paddr <= a;
		pwdata <= w ? d : 32'h0;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			fail("no bus answer");
			final_report();
		end
		{psel, penable} <= 2'b00;
		@(posedge ref_clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b0, a, d, m, 1'b0);
	endtask : rd
	task automatic wait_pins(input logic [5:0] lvl, input logic [5:0] oe);
		int k;
		for (k = 0; k < 40; k++) begin
			if (phasePins.oeN === oe && (phasePins.level & ~oe) === (lvl & ~oe)) break;
			@(posedge ref_clk);
		end
		cmp_pins(lvl, oe);
		if (k >= 40) final_report();
	endtask : wait_pins
	task automatic irq_gap(output int g);
		int k;
		k = 0;
		while (carrierIrq !== 1'b1 && k < 300) begin
			@(posedge ref_clk);
			k++;
		end
		@(posedge ref_clk);
		g = 1;
		while (carrierIrq !== 1'b1 && g < 300) begin
			@(posedge ref_clk);
			g++;
		end
		if (g >= 300) begin
			fail("no interrupt");
			final_report();
		end
	endtask : irq_gap
	// Bus answers are matched against the oldest note
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (noteQ.size() == 0) fail("answer without request");
			else cmp_bus(noteQ.pop_front());
		end
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{sys_rst, psel, penable, pwrite, sdN} = 5'b10001;
		{paddr, pwdata, gpioPins} = '0;
		lfsr = 32'hD0E7E85C;
		{numErrors, checks} = '0;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(OFS_PINSEL, 32'h3F, 32'hFF);
		apb(1'b0, 12'h3FC, 32'h0, 32'hFFFFFFFF, 1'b1);
		wr(OFS_PINSEL, 32'h0);
		rd(OFS_PINSEL, 32'h3F, 32'hFF);
		wr(OFS_PROTECT, 32'h1);
		rd(OFS_PROTECT, 32'h1, 32'h1);
		lfsr = lfsr_next(lfsr);
		sel = lfsr[5:0];
		wr(OFS_PINSEL, {26'h0, sel});
		rd(OFS_PINSEL, {26'h0, sel}, 32'hFF);
		lfsr = lfsr_next(lfsr);
		gpioPins <= lfsr[11:0];
		wr(OFS_CTRLA, 32'h08);
		wait_pins(gpioPins.level, gpioPins.oeN);
		wr(OFS_CTRLA, 32'h0C);
		wait_pins(gpioPins.level | sel, gpioPins.oeN & ~sel);
		wr(OFS_PINSEL, 32'h3F);
		wr(OFS_PROTECT, 32'h0);
		for (int h = 0; h < 2; h++) begin
			wr(OFS_CTRLB, 32'h21 | (32'(h) << CB_ACTHI));
			for (int i = 0; i < 3; i++) wr(OFS_PRI_U + 12'(4 * i), 32'd5);
			lfsr = lfsr_next(lfsr);
			p0 = lfsr[5:0];
			wr(OFS_PAT0, {26'h0, p0});
			wr(OFS_PAT1, {26'h0, ~p0});
			wr(OFS_CTRLA, 32'h8C);
			wait_pins(p0 ^ {6{h[0]}}, 6'h0);
			wr(OFS_CARRIER, 32'd20);
			wait_pins(~p0 ^ {6{h[0]}}, 6'h0);
		end
		wr(OFS_CTRLA, 32'h1C);
		wr(OFS_PAT0, 32'h3C);
		wr(OFS_PAT1, 32'h3C);
		wr(OFS_CTRLA, 32'h9C);
		wait_pins(6'h0, 6'h3F);
		rd(OFS_CTRLA, 32'h20, 32'h28);
		wr(OFS_CTRLA, 32'h0C);
		wr(OFS_PAT0, 32'h3F);
		wr(OFS_PAT1, 32'h3F);
		wr(OFS_CTRLA, 32'h8C);
		wr(OFS_CARCTL, 32'h2);
		sdN <= 1'b0;
		wait_pins(6'h0, 6'h3F);
		rd(OFS_CTRLA, 32'h0, 32'h08);
		sdN <= 1'b1;
		repeat (6) @(posedge ref_clk);
		cmp_pins(6'h0, 6'h3F);
		wr(OFS_CARCTL, 32'h0);
		wait_pins(gpioPins.level, gpioPins.oeN);
		// Complementary pairs, dead time on, count halved, shift-output trigger
		wr(OFS_CTRLB, 32'h44);
		wr(OFS_DEADTIME, 32'd10);
		wr(OFS_PAT0, 32'h2A);
		wr(OFS_CTRLA, 32'h8C);
		wait_pins(6'h2A, 6'h0);
		wr(OFS_PAT0, 32'h15);
		wr(OFS_CTRLA, 32'h8C);
		repeat (4) @(posedge ref_clk);
		cmp_pins(6'h3F, 6'h0);
		repeat (10) @(posedge ref_clk);
		cmp_pins(6'h3F, 6'h0);
		wait_pins(6'h15, 6'h0);
		for (int i = 0; i < 6; i++) begin
			wr(OFS_CARCTL, 32'h0);
			wr(OFS_CTRLB, (i >= 2) ? 32'h2 : 32'h0);
			wr(OFS_CTRLA, (i == 0) ? 32'h40 : ((i >= 2) ? 32'(i - 2) : 32'h0));
			wr(OFS_CARRIER, 32'd9);
			wr(OFS_SKIP, 32'd3);
			wr(OFS_CARCTL, 32'h1);
			irq_gap(gap);
			cmp_gap(gap, gaps[i]);
		end
		final_report();
	end
endmodule : test_tpm_pwm_core

//--- verif/tpm_gate_model.sv
// Gate driver model on the six phase pins.
// Assumes each gate input has a pull-down, so a floating pin reads low.
`timescale 1ns/10ps
module tpm_gate_model
	import tpm_pkg::*;
(
	input  wire tpm_pins_t phasePins,
	output logic [5:0]     gateSeen
);
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			gateSeen[i] = phasePins.oeN[i] ? 1'b0 : phasePins.level[i];
		end
	end
endmodule : tpm_gate_model

//--- verif/tpm_pwm_sva.sv
// Checker for the PWM output stage; sees only the ports of the top module.
// Assumes APB completes where psel, penable and pready are high together.
`timescale 1ns/10ps
module tpm_pwm_sva
	import tpm_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        shutdownInputN,
	input wire tpm_pins_t   gpioPins,
	input wire tpm_pins_t   phasePins,
	input wire logic        carrierIrq
);
	// ****
	// Register shadow from completed writes
	// ****
	logic       mtf, moe, guard, hizEn, unlock, actHi, wrDone, both, run;
	logic [5:0] pinsel, gpioMask, act;
	logic [3:0] quiet, sdLow;
	assign wrDone = psel && penable && pready && pwrite && !pslverr;
	assign gpioMask = (mtf && moe) ? ~pinsel : 6'h3F;
	assign act = ~phasePins.oeN & ~(phasePins.level ^ {6{actHi}}) & ~gpioMask;
	assign both = |({act[4], act[2], act[0]} & {act[5], act[3], act[1]});
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{mtf, moe, guard, hizEn, unlock, actHi, run} <= 7'h0;
			pinsel <= PINSEL_RST;
			quiet <= 4'h0;
			sdLow <= 4'h0;
		end else begin
			quiet <= wrDone ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
			// Cutoff stands after the pin returns high, so a count of 6 or more is kept
			if (!hizEn) sdLow <= 4'h0;
			else if (!shutdownInputN) sdLow <= (sdLow == 4'hF) ? sdLow : sdLow + 4'h1;
			else if (sdLow < 4'h6) sdLow <= 4'h0;
			if (hizEn && !shutdownInputN) moe <= 1'b0;
			if (wrDone) begin
				case (paddr)
					OFS_CTRLA: {guard, moe, mtf} <= pwdata[4:2];
					OFS_CTRLB: actHi <= pwdata[CB_ACTHI];
					OFS_CARCTL: {hizEn, run} <= pwdata[CC_HIZ:CC_RUN];
					OFS_PROTECT: unlock <= pwdata[0];
					OFS_PINSEL: if (unlock) pinsel <= pwdata[5:0];
					default: ;
				endcase
			end
		end
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && !pready ##1 psel && penable && pready;
	endsequence
	sequence s_read(logic [11:0] a);
		psel && penable && pready && !pwrite && paddr == a;
	endsequence
	a_apb_wait_state: assert property (s_setup |=> s_access)
		else $error("apb answer not after one wait cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside a completion");
	a_cutoff_float: assert property (sdLow >= 4'h6 |-> phasePins.oeN == 6'h3F)
		else $error("pins driven during forced cutoff");
	a_gpio_route: assert property (quiet >= 4'h2 && !hizEn && !guard |->
		((phasePins.level ^ $past(gpioPins.level)) & gpioMask) == 6'h0 &&
		((phasePins.oeN ^ $past(gpioPins.oeN)) & gpioMask) == 6'h0)
		else $error("port pin not following port logic");
	a_guard_float: assert property (guard && both |-> ##[0:3] phasePins.oeN == 6'h3F)
		else $error("both sides active without float");
	a_unlock_read: assert property (s_read(OFS_PROTECT) |-> prdata[0] == unlock)
		else $error("unlock bit not held");
	a_pinsel_read: assert property (s_read(OFS_PINSEL) |-> prdata[5:0] == pinsel)
		else $error("pin select changed while locked");
	a_irq_needs_run: assert property (carrierIrq |-> $past(run))
		else $error("interrupt while carrier stopped");
endmodule : tpm_pwm_sva

bind tpm_pwm_core tpm_pwm_sva chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .shutdownInputN(shutdownInputN),
	.gpioPins(gpioPins), .phasePins(phasePins), .carrierIrq(carrierIrq));
